// >>> hdl/ottf_trace_unit.sv
// Trace and trigger unit: comparators, trigger logic, capture FIFO, APB.
`timescale 1ns/1ps
module ottf_trace_unit #(
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset.
	input  wire logic                         i_clk_sys,
	input  wire logic                         i_reset,
	// APB slave.
	input  wire logic                         i_psel,
	input  wire logic                         i_penable,
	input  wire logic                         i_pwrite,
	input  wire logic [ottf_pkg::OTTF_AW-1:0] i_paddr,
	input  wire logic [31:0]                  i_pwdata,
	output logic                              o_pready,
	output logic [31:0]                       o_prdata,
	output logic                              o_pslverr,
	// CPU bus.
	input  wire logic                         i_cpu_cycle,
	input  wire logic [15:0]                  i_cpu_addr,
	input  wire logic                         i_cpu_rw,
	input  wire logic [7:0]                   i_cpu_rdata,
	input  wire logic [7:0]                   i_cpu_wdata,
	input  wire logic                         i_bdc_access,
	// Instruction queue.
	input  wire logic                         i_opfetch,
	input  wire logic                         i_q_flush,
	input  wire logic                         i_op_exec,
	input  wire logic [15:0]                  i_exec_addr,
	// Change of flow.
	input  wire logic                         i_cof_valid,
	input  wire ottf_pkg::ottf_cof_t          i_cof_kind,
	input  wire logic [15:0]                  i_cof_src,
	input  wire logic [15:0]                  i_cof_dst,
	input  wire logic [15:0]                  i_cof_hx,
	// Breakpoint request to the CPU.
	output logic                              o_brk_req,
	output logic                              o_brk_tag
);
	import ottf_pkg::*;

	// ----------------------------------------------------------------
	// Declarations.
	// ----------------------------------------------------------------
	logic [15:0] cmpa_reg, cmpa_next, cmpb_reg, cmpb_next;
	logic [7:0]  ctrl_reg, ctrl_next, trig_reg, trig_next;
	logic        pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        run_active_flag_reg, run_active_flag_next, af_reg, af_next, bf_reg, bf_next;
	logic        aseen_reg, aseen_next, stor_reg, stor_next;
	logic [1:0]  hold_reg, hold_next;
	logic [3:0]  cnt_reg, cnt_next;
	logic [15:0] lastop_reg, lastop_next;
	logic        brk_reg, brk_next, btag_reg, btag_next;
	logic [15:0] fifo_reg [DEPTH];
	logic [15:0] fifo_next [DEPTH];
	ottf_mode_t  mode;
	logic        acc, wr_ctrl, rd_low, prof_rd, arm_start, run_stop;
	logic        stop_shift, live, begin_eff, ev_mode, full_mode;
	logic        rw_ok_a, rw_ok_b, ge_a, le_b, raw_a, raw_b, d_eq;
	logic [7:0]  bdata;
	logic        qa, qb, trig, brk_cond;
	logic [1:0]  trk_hit, trk_fetch;
	logic        cof_ok, push, shift;
	logic [15:0] cof_addr, push_val, fifo_in;

	// ----------------------------------------------------------------
	// APB decode.
	// ----------------------------------------------------------------
	// The answer is prepared in the setup cycle, so no wait state.
	assign acc      = i_psel && i_penable && pready_reg;
	assign wr_ctrl  = acc && i_pwrite && i_paddr == OTTF_OFS_CTRL;
	assign rd_low   = acc && !i_pwrite && i_paddr == OTTF_OFS_FIFOL;
	assign prof_rd  = rd_low && !run_active_flag_reg;
	assign arm_start = wr_ctrl && i_pwdata[OTTF_CTRL_ARM]
		&& i_pwdata[OTTF_CTRL_DBGEN];
	assign run_stop = wr_ctrl && !arm_start && run_active_flag_reg;
	// A manual stop short of full shifts once more.
	assign stop_shift = run_stop && cnt_reg != OTTF_CNT_FULL;

	// Register writes and read data.
	always_comb begin
		cmpa_next    = cmpa_reg;
		cmpb_next    = cmpb_reg;
		ctrl_next    = ctrl_reg;
		trig_next    = trig_reg;
		pready_next  = i_psel && !i_penable;
		pslverr_next = 1'b0;
		prdata_next  = prdata_reg;
		if (acc && i_pwrite) begin
			unique case (i_paddr)
				OTTF_OFS_CMPA: cmpa_next = i_pwdata[15:0];
				OTTF_OFS_CMPB: cmpb_next = i_pwdata[15:0];
				OTTF_OFS_CTRL: ctrl_next = i_pwdata[7:0];
				OTTF_OFS_TRIG: trig_next = i_pwdata[7:0] & 8'hCF;
				default: ;
			endcase
		end
		if (i_psel && !i_penable) begin
			prdata_next = 32'h0000_0000;
			unique case (i_paddr)
				OTTF_OFS_CMPA:  prdata_next[15:0] = cmpa_reg;
				OTTF_OFS_CMPB:  prdata_next[15:0] = cmpb_reg;
				OTTF_OFS_CTRL: begin
					prdata_next[7:0] = ctrl_reg;
					prdata_next[OTTF_CTRL_ARM] = run_active_flag_reg;
				end
				OTTF_OFS_TRIG:  prdata_next[7:0] = trig_reg;
				OTTF_OFS_STAT: begin
					prdata_next[OTTF_STAT_AF]   = af_reg;
					prdata_next[OTTF_STAT_BF]   = bf_reg;
					prdata_next[OTTF_STAT_RUN_ACTIVE_FLAG] = run_active_flag_reg;
					prdata_next[3:0]            = cnt_reg;
				end
				OTTF_OFS_FIFOH: prdata_next[7:0] = fifo_reg[0][15:8];
				OTTF_OFS_FIFOL: prdata_next[7:0] = fifo_reg[0][7:0];
				default:        pslverr_next = 1'b1;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Comparators.
	// ----------------------------------------------------------------
	assign mode      = ottf_mode_t'(trig_reg[3:0]);
	assign ev_mode   = mode == OTTF_EV_B || mode == OTTF_A_THEN_EV_B;
	assign full_mode = mode == OTTF_A_AND_BD || mode == OTTF_A_NOT_BD;
	// Event-only runs are always begin type.
	assign begin_eff = trig_reg[OTTF_TRIG_BEGIN] || ev_mode;
	assign live      = i_cpu_cycle && !i_bdc_access;
	assign rw_ok_a = !ctrl_reg[OTTF_CTRL_CMP_A_RW_QUAL_EN]
		|| i_cpu_rw == ctrl_reg[OTTF_CTRL_RWAV];
	assign rw_ok_b = !ctrl_reg[OTTF_CTRL_RWBEN]
		|| i_cpu_rw == ctrl_reg[OTTF_CTRL_RWBV];
	assign ge_a = i_cpu_addr >= cmpa_reg;
	assign le_b = i_cpu_addr <= cmpb_reg;
	// Write data is chosen only when A qualifies on writes.
	assign bdata = (ctrl_reg[OTTF_CTRL_CMP_A_RW_QUAL_EN] && !ctrl_reg[OTTF_CTRL_RWAV])
		? i_cpu_wdata : i_cpu_rdata;
	assign d_eq = bdata == cmpb_reg[7:0];

	// A: equality or range; B: address equality.
	always_comb begin
		unique case (mode)
			OTTF_IN_RANGE:  raw_a = ge_a && le_b;
			OTTF_OUT_RANGE: raw_a = !(ge_a && le_b);
			default:        raw_a = i_cpu_addr == cmpa_reg;
		endcase
		raw_a = raw_a && rw_ok_a;
		raw_b = !full_mode && i_cpu_addr == cmpb_reg && rw_ok_b;
	end

	assign trk_fetch = {raw_b, raw_a} & {2{live && i_opfetch}};

	// One opcode tracker per comparator.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_trk
			ottf_op_track u_trk (
				.i_clk_sys     (i_clk_sys),
				.i_reset       (i_reset),
				.i_fetch_match (trk_fetch[gi]),
				.i_fetch_addr  (i_cpu_addr),
				.i_flush       (i_q_flush),
				.i_exec        (i_op_exec),
				.i_exec_addr   (i_exec_addr),
				.o_hit         (trk_hit[gi])
			);
		end
	endgenerate

	// Fetch-only matches never reach the trigger when tracking is on.
	assign qa = trig_reg[OTTF_TRIG_SEL] ? trk_hit[0] : raw_a && live;
	assign qb = trig_reg[OTTF_TRIG_SEL] ? trk_hit[1] : raw_b && live;

	// ----------------------------------------------------------------
	// Trigger decision.
	// ----------------------------------------------------------------
	always_comb begin
		brk_cond = 1'b0;
		unique case (mode)
			OTTF_A_ONLY, OTTF_IN_RANGE, OTTF_OUT_RANGE: trig = qa;
			OTTF_A_OR_B:      trig = qa || qb;
			OTTF_A_THEN_B:    trig = aseen_reg && qb;
			OTTF_EV_B:        trig = qb;
			OTTF_A_THEN_EV_B: trig = aseen_reg && qb;
			OTTF_A_AND_BD:    trig = qa && d_eq && live;
			OTTF_A_NOT_BD:    trig = qa && !d_eq && live;
			default:          trig = 1'b0;
		endcase
		brk_cond = trig;
		// A tagged break in a full mode ignores the data half.
		if (full_mode && ctrl_reg[OTTF_CTRL_TAG]) begin
			brk_cond = qa;
		end
		trig     = trig && run_active_flag_reg;
		brk_cond = brk_cond && run_active_flag_reg && ctrl_reg[OTTF_CTRL_BRKEN];
	end

	// ----------------------------------------------------------------
	// Change-of-flow capture.
	// ----------------------------------------------------------------
	always_comb begin
		cof_ok   = i_cof_valid;
		cof_addr = 16'h0000;
		unique case (i_cof_kind)
			OTTF_COF_BRCOND:  cof_addr = i_cof_src;
			OTTF_COF_INDJUMP: cof_addr = i_cof_hx;
			OTTF_COF_INTR,
			OTTF_COF_RETURN:  cof_addr = i_cof_dst;
			OTTF_COF_BRFIXED,
			OTTF_COF_NONE:    cof_ok = 1'b0;
			default:          cof_ok = 1'b0;
		endcase
		// Begin runs skip the trigger cycle and the hold-off window.
		if (begin_eff) begin
			cof_ok = cof_ok && stor_reg && hold_reg == 2'h0;
		end
		// An end run stores a triggering change of flow before ending.
	end

	// At most one word enters the FIFO per cycle.
	assign push = run_active_flag_reg && (ev_mode ? trig : cof_ok);
	assign push_val = ev_mode ? {8'h00, bdata} : cof_addr;
	assign shift = push || rd_low || stop_shift;
	assign fifo_in = push ? push_val : (prof_rd ? lastop_reg : 16'h0000);

	// Shift register: write at the tail, read at entry zero.
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_fifo
			if (gi == DEPTH - 1) begin : g_tail
				assign fifo_next[gi] = shift ? fifo_in : fifo_reg[gi];
			end else begin : g_body
				assign fifo_next[gi] = shift ? fifo_reg[gi+1]
					: fifo_reg[gi];
			end
			always_ff @(posedge i_clk_sys) begin
				if (i_reset) begin
					fifo_reg[gi] <= 16'h0000;
				end else begin
					fifo_reg[gi] <= fifo_next[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Run control and status.
	// ----------------------------------------------------------------
	always_comb begin
		run_active_flag_next   = run_active_flag_reg;
		af_next     = af_reg;
		bf_next     = bf_reg;
		aseen_next  = aseen_reg;
		stor_next   = stor_reg;
		hold_next   = hold_reg;
		cnt_next    = cnt_reg;
		lastop_next = lastop_reg;
		brk_next    = brk_cond;
		btag_next   = brk_cond && ctrl_reg[OTTF_CTRL_TAG];
		if (live && i_opfetch) begin
			lastop_next = i_cpu_addr;
		end
		// Count saturates at full; profiling reads refill it.
		if ((push || prof_rd) && cnt_reg != OTTF_CNT_FULL) begin
			cnt_next = cnt_reg + 4'h1;
		end else if (rd_low && !push && !prof_rd && cnt_reg != 4'h0) begin
			cnt_next = cnt_reg - 4'h1;
		end
		if (arm_start) begin
			run_active_flag_next  = 1'b1;
			af_next    = 1'b0;
			bf_next    = 1'b0;
			cnt_next   = 4'h0;
			aseen_next = 1'b0;
			stor_next  = 1'b0;
			hold_next  = 2'h0;
		end else if (run_stop) begin
			run_active_flag_next = 1'b0;
		end else if (run_active_flag_reg) begin
			af_next    = af_reg || qa;
			bf_next    = bf_reg || qb;
			aseen_next = aseen_reg || qa;
			if (trig && begin_eff && !stor_reg) begin
				stor_next = 1'b1;
				hold_next = OTTF_HOLDOFF;
			end else if (hold_reg != 2'h0 && i_cpu_cycle) begin
				hold_next = hold_reg - 2'h1;
			end
			if (trig && !begin_eff) begin
				run_active_flag_next = 1'b0;
			end
			if (begin_eff && cnt_next == OTTF_CNT_FULL) begin
				run_active_flag_next = 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// State registers.
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			cmpa_reg    <= OTTF_CMP_RST;
			cmpb_reg    <= OTTF_CMP_RST;
			ctrl_reg    <= OTTF_CTRL_RST;
			trig_reg    <= OTTF_TRIG_RST;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			run_active_flag_reg    <= 1'b0;
			af_reg      <= 1'b0;
			bf_reg      <= 1'b0;
			aseen_reg   <= 1'b0;
			stor_reg    <= 1'b0;
			hold_reg    <= 2'h0;
			cnt_reg     <= 4'h0;
			lastop_reg  <= 16'h0000;
			brk_reg     <= 1'b0;
			btag_reg    <= 1'b0;
		end else begin
			cmpa_reg    <= cmpa_next;
			cmpb_reg    <= cmpb_next;
			ctrl_reg    <= ctrl_next;
			trig_reg    <= trig_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg  <= prdata_next;
			run_active_flag_reg    <= run_active_flag_next;
			af_reg      <= af_next;
			bf_reg      <= bf_next;
			aseen_reg   <= aseen_next;
			stor_reg    <= stor_next;
			hold_reg    <= hold_next;
			cnt_reg     <= cnt_next;
			lastop_reg  <= lastop_next;
			brk_reg     <= brk_next;
			btag_reg    <= btag_next;
		end
	end

	// Every output is a flip-flop.
	assign o_pready  = pready_reg;
	assign o_pslverr = pslverr_reg;
	assign o_prdata  = prdata_reg;
	assign o_brk_req = brk_reg;
	assign o_brk_tag = btag_reg;
endmodule : ottf_trace_unit

// >>> hdl/ottf_pkg.sv
// Constants and types of the trace and trigger unit.
package ottf_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses on the APB).
	// ----------------------------------------------------------------
	localparam int unsigned OTTF_AW     = 8;
	localparam logic [7:0]  OTTF_OFS_CMPA  = 8'h00;
	localparam logic [7:0]  OTTF_OFS_CMPB  = 8'h04;
	localparam logic [7:0]  OTTF_OFS_CTRL  = 8'h08;
	localparam logic [7:0]  OTTF_OFS_TRIG  = 8'h0C;
	localparam logic [7:0]  OTTF_OFS_STAT  = 8'h10;
	localparam logic [7:0]  OTTF_OFS_FIFOH = 8'h14;
	localparam logic [7:0]  OTTF_OFS_FIFOL = 8'h18;

	// ----------------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------------
	localparam int unsigned OTTF_CTRL_DBGEN = 7;
	localparam int unsigned OTTF_CTRL_ARM   = 6;
	localparam int unsigned OTTF_CTRL_TAG   = 5;
	localparam int unsigned OTTF_CTRL_BRKEN = 4;
	localparam int unsigned OTTF_CTRL_RWAV  = 3;
	localparam int unsigned OTTF_CTRL_CMP_A_RW_QUAL_EN = 2;
	localparam int unsigned OTTF_CTRL_RWBV  = 1;
	localparam int unsigned OTTF_CTRL_RWBEN = 0;
	localparam int unsigned OTTF_TRIG_SEL   = 7;
	localparam int unsigned OTTF_TRIG_BEGIN = 6;
	localparam int unsigned OTTF_STAT_AF    = 7;
	localparam int unsigned OTTF_STAT_BF    = 6;
	localparam int unsigned OTTF_STAT_RUN_ACTIVE_FLAG  = 5;

	// ----------------------------------------------------------------
	// Reset values and counts.
	// ----------------------------------------------------------------
	localparam logic [15:0] OTTF_CMP_RST   = 16'h0000;
	localparam logic [7:0]  OTTF_CTRL_RST  = 8'h00;
	localparam logic [7:0]  OTTF_TRIG_RST  = 8'h00;
	localparam logic [3:0]  OTTF_CNT_FULL  = 4'h8;
	localparam logic [1:0]  OTTF_HOLDOFF   = 2'h2;

	// Trigger modes; codes above the last one never trigger.
	typedef enum logic [3:0] {
		OTTF_A_ONLY      = 4'h0,
		OTTF_A_OR_B      = 4'h1,
		OTTF_A_THEN_B    = 4'h2,
		OTTF_EV_B        = 4'h3,
		OTTF_A_THEN_EV_B = 4'h4,
		OTTF_A_AND_BD    = 4'h5,
		OTTF_A_NOT_BD    = 4'h6,
		OTTF_IN_RANGE    = 4'h7,
		OTTF_OUT_RANGE   = 4'h8
	} ottf_mode_t;

	// Kind of change of flow reported by the CPU.
	typedef enum logic [2:0] {
		OTTF_COF_NONE    = 3'h0,
		OTTF_COF_BRCOND  = 3'h1,
		OTTF_COF_BRFIXED = 3'h2,
		OTTF_COF_INDJUMP = 3'h3,
		OTTF_COF_INTR    = 3'h4,
		OTTF_COF_RETURN  = 3'h5
	} ottf_cof_t;

endpackage : ottf_pkg

// >>> hdl/ottf_op_track.sv
// Opcode tracker: turns a fetch-time match into an execute-time hit.
`timescale 1ns/1ps
module ottf_op_track (
	// Clock and reset.
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset,
	// Fetch side.
	input  wire logic        i_fetch_match,
	input  wire logic [15:0] i_fetch_addr,
	input  wire logic        i_flush,
	// Execute side.
	input  wire logic        i_exec,
	input  wire logic [15:0] i_exec_addr,
	output logic             o_hit
);
	logic        pend_reg, pend_next;
	logic [15:0] addr_reg, addr_next;
	logic        hit_reg,  hit_next;

	// A queue flush throws the tagged opcode away, so it hits only if it executes in the flush cycle.
	always_comb begin
		pend_next = pend_reg;
		addr_next = addr_reg;
		hit_next  = 1'b0;
		if (i_exec && pend_reg && i_exec_addr == addr_reg) begin
			hit_next  = 1'b1;
			pend_next = 1'b0;
		end
		if (i_flush) begin
			pend_next = 1'b0;
		end
		if (i_fetch_match) begin
			pend_next = 1'b1;
			addr_next = i_fetch_addr;
		end
	end

	// State registers.
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			pend_reg <= 1'b0;
			addr_reg <= 16'h0000;
			hit_reg  <= 1'b0;
		end else begin
			pend_reg <= pend_next;
			addr_reg <= addr_next;
			hit_reg  <= hit_next;
		end
	end

	assign o_hit = hit_reg;
endmodule : ottf_op_track

// >>> dv/ottf_cpu_model.sv
// CPU core model: bus cycles, instruction queue events, change of flow.
`timescale 1ns/1ps
module ottf_cpu_model (
	// Clock.
	input  wire logic           i_clk_sys,
	// CPU bus.
	output logic                o_cyc,
	output logic [15:0]         o_addr,
	output logic                o_rw,
	output logic [7:0]          o_rd,
	output logic [7:0]          o_wd,
	output logic                o_bdc,
	// Queue and change of flow.
	output logic                o_fetch,
	output logic                o_flush,
	output logic                o_exec,
	output logic [15:0]         o_exa,
	output logic                o_cof,
	output ottf_pkg::ottf_cof_t o_kind,
	output logic [15:0]         o_src,
	output logic [15:0]         o_dst,
	output logic [15:0]         o_hx
);
	import ottf_pkg::*;
	// ----------------------------------------------------------------
	// Drivers.
	// ----------------------------------------------------------------
	// Quiet bus at time zero.
	initial begin
		{o_cyc, o_rw, o_bdc, o_fetch, o_flush, o_exec, o_cof} = '0;
		{o_addr, o_rd, o_wd, o_exa, o_src, o_dst, o_hx} = '0;
		o_kind = OTTF_COF_NONE;
	end
	// A clock with no bus cycle; stale address and read data are inverted.
	task automatic idle();
		@(posedge i_clk_sys);
		o_cyc   <= 1'b0;
		o_addr  <= ~o_addr;
		o_rd    <= ~o_rd;
		o_fetch <= 1'b0;
		o_flush <= 1'b0;
		o_exec  <= 1'b0;
		o_cof   <= 1'b0;
	endtask : idle
	// One bus cycle per clock, at most.
	task automatic cyc(input logic [15:0] a,
		input ottf_cof_t k = OTTF_COF_NONE, input logic [15:0] d = 16'h0,
		input logic rw = 1'b1, input logic bdc = 1'b0, input logic fe = 1'b0,
		input logic [7:0] rd = 8'h00, input logic [7:0] wd = 8'h00);
		@(posedge i_clk_sys);
		o_cyc   <= 1'b1;
		o_addr  <= a;
		o_rw    <= rw;
		o_bdc   <= bdc;
		o_fetch <= fe;
		o_rd    <= rd;
		o_wd    <= wd;
		o_exec  <= 1'b0;
		o_flush <= 1'b0;
		o_cof   <= (k != OTTF_COF_NONE);
		o_kind  <= k;
		o_src   <= d;
		o_dst   <= d ^ 16'h0F0F;
		o_hx    <= d ^ 16'hF0F0;
	endtask : cyc
	// The fetched opcode executes, or the queue is thrown away.
	task automatic ex(input logic [15:0] a, input logic fl);
		@(posedge i_clk_sys);
		o_cyc   <= 1'b0;
		o_fetch <= 1'b0;
		o_cof   <= 1'b0;
		o_exec  <= !fl;
		o_flush <= fl;
		o_exa   <= a;
	endtask : ex
endmodule : ottf_cpu_model

// >>> dv/ottf_trace_unit_sva.sv
// Concurrent checks on the ports of the trace and trigger unit.
`timescale 1ns/1ps
module ottf_trace_unit_sva #(
	parameter int unsigned AW = ottf_pkg::OTTF_AW
) (
	// Clock and reset.
	input  wire logic          i_clk_sys,
	input  wire logic          i_reset,
	// APB.
	input  wire logic          i_psel,
	input  wire logic          i_penable,
	input  wire logic [AW-1:0] i_paddr,
	input  wire logic          o_pready,
	input  wire logic [31:0]   o_prdata,
	input  wire logic          o_pslverr,
	// CPU side and break.
	input  wire logic          i_cpu_cycle,
	input  wire logic          i_bdc_access,
	input  wire logic          i_op_exec,
	input  wire logic          o_brk_req,
	input  wire logic          o_brk_tag
);
	import ottf_pkg::*;
	// ----------------------------------------------------------------
	// Properties.
	// ----------------------------------------------------------------
	logic unmapped;
	// No register past the last port or off a word.
	assign unmapped = (i_paddr > OTTF_OFS_FIFOL) || (i_paddr[1:0] != 2'h0);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_access;
		i_psel && i_penable && o_pready;
	endsequence
	AST_ZERO_WAIT: assert property (s_setup |=> s_access)
		else $error("no access after setup");
	AST_READY_CAUSE: assert property (o_pready |->
		$past(i_psel) && !$past(i_penable))
		else $error("pready without setup");
	AST_READY_ONE: assert property (o_pready |=> !o_pready)
		else $error("pready stood longer than one cycle");
	AST_UNMAPPED: assert property (s_setup ##0 unmapped |=>
		o_pslverr && o_prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_MAPPED: assert property (s_setup ##0 !unmapped |=> !o_pslverr)
		else $error("error on a mapped register");
	AST_UPPER_ZERO: assert property (o_pready |->
		o_prdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	AST_BRK_CAUSE: assert property (o_brk_req |->
		($past(i_cpu_cycle) && !$past(i_bdc_access)) || $past(i_op_exec, 2))
		else $error("break without a qualifying cycle");
	AST_TAG_WITH_REQ: assert property (o_brk_tag |-> o_brk_req)
		else $error("break tag without a break request");
endmodule : ottf_trace_unit_sva
bind ottf_trace_unit ottf_trace_unit_sva u_sva (.*);

// >>> dv/tb_top.sv
// Self-checking testbench of the trace and trigger unit.
`timescale 1ns/1ps
module tb_top;
	import ottf_pkg::*;
	// ----------------------------------------------------------------
	// Signals, design and CPU model.
	// ----------------------------------------------------------------
	logic        i_clk_sys = 1'b0;
	logic        i_reset = 1'b1;
	logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [7:0]  i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0;
	logic        o_pready, o_pslverr, o_brk_req, o_brk_tag, slv;
	logic [31:0] o_prdata, rv;
	logic        i_cpu_cycle, i_cpu_rw, i_bdc_access, i_opfetch;
	logic        i_q_flush, i_op_exec, i_cof_valid;
	logic [15:0] i_cpu_addr, i_exec_addr, i_cof_src, i_cof_dst, i_cof_hx;
	logic [7:0]  i_cpu_rdata, i_cpu_wdata;
	ottf_cof_t   i_cof_kind;
	int          err_total = 0;
	int          num_checks = 0;
	int          brk_n = 0;
	always #5 i_clk_sys = ~i_clk_sys;
	// Counts one-cycle break pulses; a tag-type pulse counts twice.
	always @(posedge i_clk_sys) if (o_brk_req === 1'b1)
		brk_n += (o_brk_tag === 1'b1) ? 2 : 1;
	ottf_trace_unit #(.DEPTH(8)) DUT (.*);
	ottf_cpu_model cpu (
		.i_clk_sys, .o_cyc(i_cpu_cycle), .o_addr(i_cpu_addr),
		.o_rw(i_cpu_rw), .o_rd(i_cpu_rdata), .o_wd(i_cpu_wdata),
		.o_bdc(i_bdc_access), .o_fetch(i_opfetch), .o_flush(i_q_flush),
		.o_exec(i_op_exec), .o_exa(i_exec_addr), .o_cof(i_cof_valid),
		.o_kind(i_cof_kind), .o_src(i_cof_src), .o_dst(i_cof_dst),
		.o_hx(i_cof_hx));
	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer, held until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n = 0;
		@(posedge i_clk_sys);
		i_psel    <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite  <= w;
		i_paddr   <= a;
		i_pwdata  <= d;
		@(posedge i_clk_sys);
		i_penable <= 1'b1;
		@(posedge i_clk_sys);
		while (o_pready !== 1'b1 && n < 20) begin
			@(posedge i_clk_sys);
			n++;
		end
		if (n == 20) err_total++;
		rv = o_prdata;
		slv = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rv, e);
	endtask : rdc
	// A coherent FIFO word: high port first, the low read shifts.
	task automatic rdw(output logic [15:0] w);
		logic [7:0] h;
		apb(1'b0, OTTF_OFS_FIFOH, 32'h0);
		h = rv[7:0];
		apb(1'b0, OTTF_OFS_FIFOL, 32'h0);
		w = {h, rv[7:0]};
	endtask : rdw
	// Flags f: [0] read, [1] debug link, [2] fetch tracked, [3] flush.
	task automatic bk(input logic [7:0] c, input logic [15:0] a,
		input logic [3:0] f, input int e, input logic [7:0] r = 8'h00,
		input logic [7:0] w = 8'h00);
		int n0;
		apb(1'b1, OTTF_OFS_CTRL, 32'h0);
		apb(1'b1, OTTF_OFS_CTRL, {24'h0, c});
		n0 = brk_n;
		cpu.cyc(a, OTTF_COF_NONE, 16'h0, f[0], f[1], f[2], r, w);
		if (f[2]) cpu.ex(a, f[3]);
		repeat (4) cpu.idle();
		chk(32'(brk_n - n0), 32'(e));
	endtask : bk
	// Begin run on comparator A, triggered at 2000.
	task automatic arm_a(input ottf_cof_t k, input logic [15:0] d);
		apb(1'b1, OTTF_OFS_CTRL, 32'h0);
		apb(1'b1, OTTF_OFS_CMPA, 32'h2000);
		apb(1'b1, OTTF_OFS_TRIG, 32'h40);
		apb(1'b1, OTTF_OFS_CTRL, 32'hC0);
		cpu.cyc(16'h2000, k, d);
	endtask : arm_a
	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task automatic t_regs();
		for (int i = 0; i < 7; i++) begin
			rdc(8'(4 * i), 32'h0);
		end
		rdc(8'h1C, 32'h0);
		chk(32'(slv), 32'h1);
		apb(1'b1, OTTF_OFS_CMPA, 32'hFFFF_ABCD);
		rdc(OTTF_OFS_CMPA, 32'h0000_ABCD);
		$display("test regs done");
	endtask : t_regs
	task automatic t_brk();
		logic [15:0] ra [4];
		ra = '{16'h00FF, 16'h0100, 16'h01FF, 16'h0200};
		apb(1'b1, OTTF_OFS_TRIG, 32'h0);
		apb(1'b1, OTTF_OFS_CMPA, 32'h1234);
		apb(1'b1, OTTF_OFS_CMPB, 32'h005A);
		bk(8'hD0, 16'h1234, 4'h1, 1);
		bk(8'hD0, 16'h1234, 4'h3, 0);
		bk(8'hD0, 16'h1235, 4'h1, 0);
		bk(8'hD4, 16'h1234, 4'h1, 0);
		bk(8'hD4, 16'h1234, 4'h0, 1);
		apb(1'b1, OTTF_OFS_TRIG, 32'h5);
		bk(8'hD4, 16'h1234, 4'h0, 1, 8'hA5, 8'h5A);
		bk(8'hD4, 16'h1234, 4'h0, 0, 8'h5A, 8'hA5);
		bk(8'hD0, 16'h1234, 4'h1, 1, 8'h5A, 8'hA5);
		bk(8'hF4, 16'h1234, 4'h0, 2, 8'h5A, 8'hA5);
		apb(1'b1, OTTF_OFS_TRIG, 32'h80);
		bk(8'hD0, 16'h1234, 4'hD, 0);
		bk(8'hD0, 16'h1234, 4'h5, 1);
		apb(1'b1, OTTF_OFS_CMPA, 32'h0100);
		apb(1'b1, OTTF_OFS_CMPB, 32'h01FF);
		for (int m = 7; m < 9; m++) begin
			apb(1'b1, OTTF_OFS_TRIG, 32'(m));
			for (int i = 0; i < 4; i++) begin
				bk(8'hD0, ra[i], 4'h1,
					int'(((i == 1) || (i == 2)) == (m == 7)));
			end
		end
		$display("test breaks done");
	endtask : t_brk
	task automatic t_event();
		apb(1'b1, OTTF_OFS_CTRL, 32'h0);
		apb(1'b1, OTTF_OFS_CMPA, 32'h9999);
		apb(1'b1, OTTF_OFS_CMPB, 32'h0040);
		apb(1'b1, OTTF_OFS_TRIG, 32'(OTTF_EV_B));
		apb(1'b1, OTTF_OFS_CTRL, 32'hC0);
		cpu.cyc(16'h0040, OTTF_COF_NONE, 16'h0, 1'b1, 1'b1, 1'b0, 8'h55);
		for (int i = 0; i < 8; i++) begin
			cpu.cyc(16'h0040, OTTF_COF_NONE, 16'h0, 1'b1, 1'b0, 1'b0,
				8'(8'hA0 + i));
		end
		cpu.idle();
		rdc(OTTF_OFS_STAT, 32'h48);
		rdc(OTTF_OFS_FIFOH, 32'h0);
		for (int i = 0; i < 8; i++) begin
			rdc(OTTF_OFS_FIFOL, 32'(8'hA0 + i));
		end
		apb(1'b1, OTTF_OFS_CTRL, 32'hC0);
		rdc(OTTF_OFS_STAT, 32'h20);
		$display("test event done");
	endtask : t_event
	task automatic t_cof();
		ottf_cof_t   ks [12];
		logic [15:0] q [$];
		logic [15:0] d, w;
		ks = '{3: OTTF_COF_BRFIXED, 5: OTTF_COF_INDJUMP, 6: OTTF_COF_INTR,
			7: OTTF_COF_RETURN, default: OTTF_COF_BRCOND};
		arm_a(ks[0], 16'h0123);
		// Unconditional branches leave no entry.
		for (int i = 1; i < 12; i++) begin
			d = 16'(i * 16'h1111 + 16'h0123);
			cpu.cyc(16'h0300, ks[i], d);
			if (i > 2 && ks[i] == OTTF_COF_BRCOND) q.push_back(d);
			if (ks[i] == OTTF_COF_INDJUMP) q.push_back(d ^ 16'hF0F0);
			if (ks[i] > OTTF_COF_INDJUMP) q.push_back(d ^ 16'h0F0F);
		end
		cpu.idle();
		rdc(OTTF_OFS_STAT, 32'h88);
		for (int i = 0; i < 8; i++) begin
			rdw(w);
			chk(32'(w), 32'(q[i]));
		end
		$display("test change of flow done");
	endtask : t_cof
	task automatic t_stop();
		logic [15:0] w;
		arm_a(OTTF_COF_NONE, 16'h0);
		repeat (2) cpu.cyc(16'h0300);
		for (int i = 0; i < 3; i++) begin
			cpu.cyc(16'h0300, OTTF_COF_BRCOND, 16'(16'hD000 + i));
		end
		cpu.idle();
		apb(1'b1, OTTF_OFS_CTRL, 32'h0);
		repeat (4) apb(1'b0, OTTF_OFS_FIFOL, 32'h0);
		for (int i = 0; i < 3; i++) begin
			rdw(w);
			chk(32'(w), 32'(16'hD000 + i));
		end
		$display("test manual stop done");
	endtask : t_stop
	task automatic t_prof();
		logic [15:0] w;
		apb(1'b1, OTTF_OFS_CTRL, 32'h0);
		cpu.cyc(16'h3456, OTTF_COF_NONE, 16'h0, 1'b1, 1'b0, 1'b1);
		cpu.idle();
		repeat (8) apb(1'b0, OTTF_OFS_FIFOL, 32'h0);
		cpu.cyc(16'h789A, OTTF_COF_NONE, 16'h0, 1'b1, 1'b0, 1'b1);
		cpu.idle();
		repeat (8) apb(1'b0, OTTF_OFS_FIFOL, 32'h0);
		rdw(w);
		chk(32'(w), 32'h0000_789A);
		$display("test profiling done");
	endtask : t_prof
	// ----------------------------------------------------------------
	// Sequence, watchdog and verdict.
	// ----------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (12) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		t_regs();
		t_brk();
		t_event();
		t_cof();
		t_stop();
		t_prof();
		print_verdict();
	end
	// Far beyond the few hundred cycles that the run needs.
	initial begin
		#200us;
		err_total++;
		print_verdict();
	end
endmodule : tb_top
